//--- hw/spm_motion_ctrl.sv
// speed control and speed control push-motion sequencer with AHB-Lite registers
//
// Function
// - run at selected entry speed while commanded
// - entry change retargets speed without stopping
// - speed command release starts decelerating stop
// - same direction during decel re-accelerates
// - both speed commands give decelerating stop
// - forward command forward, reverse command reverse
// - accept: ready low, move high, then run
// - at rest: ready high, move low
// - signed entry speed, +-4000000, default 1000
// - start/change rate 1..1e9, default 1e6
// - separate stop deceleration per entry
// - entry current 0..1000, push current too
// - common starting speed 0..4000000, default 500
// - push command runs at selected entry speed
// - push command release starts decelerating stop
// - both push commands give decelerating stop
// - push status: deviation grows, holds at limit
// - five seconds overload: alarm and stop
//
// Our own choices: register access over AHB-Lite and the register offsets.
`default_nettype none
module spm_motion_ctrl #(
  parameter int unsigned OVERLOAD_CYC = spm_pkg::OVERLOAD_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // host direct inputs
  input wire logic fwd_speed_cmd,
  input wire logic rev_speed_cmd,
  input wire logic fwd_push_cmd,
  input wire logic rev_push_cmd,
  input wire logic data_select_bit0,
  input wire logic data_select_bit1,
  input wire logic data_select_bit2,
  // motor feedback
  input wire logic motorBlocked,
  // host direct outputs
  output logic readyOut,
  output logic moveOut,
  output logic alarmOut,
  output logic torque_limit_flag,
  // motor drive
  output logic stepPulse,
  output logic stepDirRev,
  output logic [9:0] currentSet
);
  ////////////////////////////////////////////////////////////////////////////
  localparam int SEL_W_T = spm_pkg::SEL_W;
  spm_pkg::spm_core_s r;
  spm_pkg::spm_core_s n;
  spm_pkg::spm_cmd_s cmd;
  spm_pkg::spm_entry_s ent;
  logic spdAny;
  logic reqPush;
  logic reqFwd;
  logic reqRev;
  logic conflict;
  logic holdCmd;
  logic clrAlarm;
  logic kill;
  logic signed [31:0] opTarget;
  logic signed [31:0] rampTarget;
  logic [31:0] rampRate;
  logic signed [31:0] speedNow;
  logic [31:0] mag;
  logic [32:0] phSum;
  logic busHit;
  logic [9:0] rdAddr;
  logic [SEL_W_T-1:0] wIdx;

  assign cmd = '{fwdSpeed: fwd_speed_cmd, revSpeed: rev_speed_cmd,
                 fwdPush: fwd_push_cmd, revPush: rev_push_cmd};
  // a speed command outranks a push command when both groups are active
  assign spdAny = cmd.fwdSpeed | cmd.revSpeed;
  assign reqPush = !spdAny;
  assign reqFwd = spdAny ? cmd.fwdSpeed : cmd.fwdPush;
  assign reqRev = spdAny ? cmd.revSpeed : cmd.revPush;
  assign conflict = reqFwd & reqRev;
  // running command still held: same mode, same direction, no clash
  assign holdCmd = !conflict && reqPush == r.modePush
                   && (r.dirRev ? reqRev : reqFwd);
  assign ent = r.tbl[r.sel];
  // reverse command mirrors the stored signed speed
  assign opTarget = r.dirRev ? -ent.speed : ent.speed;
  assign kill = r.state == spm_pkg::ST_ALARM;
  assign rampTarget = r.state == spm_pkg::ST_RUN ? opTarget : '0;
  assign rampRate = r.state == spm_pkg::ST_RUN ? ent.rate : ent.stopDec;
  assign clrAlarm = r.busWr && r.busAddr == spm_pkg::CTRL_OFS
                    && hwdata[spm_pkg::CTRL_CLR_BIT];
  assign busHit = hsel && hready && htrans[1] && haddr[31:10] == '0;
  assign rdAddr = haddr[9:0];
  assign wIdx = r.busAddr[6:4];

  spm_ramp u_ramp (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .target(rampTarget),
    .rate(rampRate),
    .startSpeed(r.startSpeed),
    .kill(kill),
    .speedNow(speedNow)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    mag = speedNow < 0 ? 32'(-speedNow) : 32'(speedNow);
    phSum = {1'b0, r.phase} + {1'b0, mag};
    // data phase write; out-of-range values are dropped
    if (r.busWr) begin
      if (r.busAddr < spm_pkg::TBL_END) begin
        unique case (r.busAddr[3:2])
          spm_pkg::ENT_SPEED: begin
            if ($signed(hwdata) <= spm_pkg::SPEED_MAX
                && $signed(hwdata) >= -spm_pkg::SPEED_MAX) begin
              n.tbl[wIdx].speed = $signed(hwdata);
            end
          end
          spm_pkg::ENT_RATE: begin
            if (hwdata >= spm_pkg::RATE_MIN && hwdata <= spm_pkg::RATE_MAX) begin
              n.tbl[wIdx].rate = hwdata;
            end
          end
          spm_pkg::ENT_STOP: begin
            if (hwdata >= spm_pkg::RATE_MIN && hwdata <= spm_pkg::RATE_MAX) begin
              n.tbl[wIdx].stopDec = hwdata;
            end
          end
          spm_pkg::ENT_CUR: begin
            if (hwdata <= spm_pkg::CUR_MAX) begin
              n.tbl[wIdx].current = hwdata[9:0];
            end
          end
        endcase
      end else if (r.busAddr == spm_pkg::START_OFS) begin
        if ($signed(hwdata) <= spm_pkg::SPEED_MAX && !hwdata[31]) begin
          n.startSpeed = hwdata;
        end
      end else if (r.busAddr == spm_pkg::DEVLIM_OFS) begin
        n.devLimit = hwdata;
      end
    end
    // operation number follows the select pins while idle or running
    if (r.state == spm_pkg::ST_IDLE || r.state == spm_pkg::ST_RUN) begin
      n.sel = {data_select_bit2, data_select_bit1, data_select_bit0};
    end
    // sequencer
    unique case (r.state)
      spm_pkg::ST_IDLE: begin
        // the host is expected to wait for ready
        if ((reqFwd || reqRev) && !conflict) begin
          n.state = spm_pkg::ST_RUN;
          n.dirRev = reqRev;
          n.modePush = reqPush;
        end
      end
      spm_pkg::ST_RUN: begin
        if (!holdCmd) begin
          n.state = spm_pkg::ST_DECEL;
        end
      end
      spm_pkg::ST_DECEL: begin
        if (holdCmd) begin
          n.state = spm_pkg::ST_RUN;
        end else if (speedNow == 0) begin
          n.state = spm_pkg::ST_IDLE;
        end
      end
      spm_pkg::ST_ALARM: begin
        if (clrAlarm) begin
          n.state = spm_pkg::ST_IDLE;
        end
      end
    endcase
    // push status: commanded steps pile up as deviation until the limit
    if (r.modePush && motorBlocked && (r.state == spm_pkg::ST_RUN
        || r.state == spm_pkg::ST_DECEL)) begin
      if (r.stepOut && r.deviation < r.devLimit) begin
        n.deviation = r.deviation + 32'h1;
      end
    end else begin
      n.deviation = '0;
    end
    n.tlcOut = r.modePush && motorBlocked && n.deviation >= r.devLimit
               && r.state != spm_pkg::ST_IDLE && r.state != spm_pkg::ST_ALARM;
    // overload timer; the alarm kills the ramp at once
    if (r.tlcOut && r.state != spm_pkg::ST_ALARM) begin
      if (r.ovlCnt >= OVERLOAD_CYC - 1) begin
        n.state = spm_pkg::ST_ALARM;
        n.ovlCnt = '0;
      end else begin
        n.ovlCnt = r.ovlCnt + 32'h1;
      end
    end else begin
      n.ovlCnt = '0;
    end
    n.alarmOut = n.state == spm_pkg::ST_ALARM;
    n.readyOut = n.state == spm_pkg::ST_IDLE;
    n.moveOut = n.state == spm_pkg::ST_RUN || n.state == spm_pkg::ST_DECEL;
    n.currentOut = ent.current;
    // step pulse by phase accumulation; held back while deviation is fixed
    n.stepDir = speedNow < 0;
    if (speedNow == 0) begin
      n.phase = '0;
      n.stepOut = 1'b0;
    end else if (n.tlcOut) begin
      n.stepOut = 1'b0;
    end else if (phSum >= {1'b0, spm_pkg::CLK_HZ}) begin
      n.phase = 32'(phSum - {1'b0, spm_pkg::CLK_HZ});
      n.stepOut = 1'b1;
    end else begin
      n.phase = phSum[31:0];
      n.stepOut = 1'b0;
    end
    // address phase; read data comes from the updated copy so a read
    // right behind a write sees the new value
    n.busWr = busHit && hwrite;
    n.busAddr = haddr[9:0];
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
    n.hrdata = '0;
    if (busHit && !hwrite) begin
      if (rdAddr < spm_pkg::TBL_END) begin
        unique case (rdAddr[3:2])
          spm_pkg::ENT_SPEED: n.hrdata = n.tbl[rdAddr[6:4]].speed;
          spm_pkg::ENT_RATE: n.hrdata = n.tbl[rdAddr[6:4]].rate;
          spm_pkg::ENT_STOP: n.hrdata = n.tbl[rdAddr[6:4]].stopDec;
          spm_pkg::ENT_CUR: n.hrdata = {22'h0, n.tbl[rdAddr[6:4]].current};
        endcase
      end else if (rdAddr == spm_pkg::START_OFS) begin
        n.hrdata = n.startSpeed;
      end else if (rdAddr == spm_pkg::DEVLIM_OFS) begin
        n.hrdata = n.devLimit;
      end else if (rdAddr == spm_pkg::STATUS_OFS) begin
        n.hrdata = {21'h0, r.sel, 2'h0, r.dirRev, r.modePush,
                    r.tlcOut, r.alarmOut, r.moveOut, r.readyOut};
      end else if (rdAddr == spm_pkg::SPEED_OFS) begin
        n.hrdata = speedNow;
      end else if (rdAddr == spm_pkg::DEV_OFS) begin
        n.hrdata = r.deviation;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.state <= spm_pkg::ST_IDLE;
      r.readyOut <= 1'b1;
      r.hreadyout <= 1'b1;
      r.currentOut <= spm_pkg::CUR_RST;
      r.startSpeed <= spm_pkg::START_RST;
      r.devLimit <= spm_pkg::DEVLIM_RST;
      for (int i = 0; i < spm_pkg::N_ENT; i++) begin
        r.tbl[i] <= '{speed: spm_pkg::SPEED_RST, rate: spm_pkg::RATE_RST,
                      stopDec: spm_pkg::RATE_RST, current: spm_pkg::CUR_RST};
      end
    end else begin
      r <= n;
    end
  end

  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign hrdata = r.hrdata;
  assign readyOut = r.readyOut;
  assign moveOut = r.moveOut;
  assign alarmOut = r.alarmOut;
  assign torque_limit_flag = r.tlcOut;
  assign stepPulse = r.stepOut;
  assign stepDirRev = r.stepDir;
  assign currentSet = r.currentOut;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence idleFwdSeq;
    r.state == spm_pkg::ST_IDLE && reqFwd && !reqRev && r.tlcOut == 1'b0;
  endsequence
  sequence startedSeq;
    !readyOut && moveOut && r.state == spm_pkg::ST_RUN && !r.dirRev;
  endsequence

  accept_handshake_a: assert property (idleFwdSeq |=> startedSeq)
    else $error("accept did not drop ready and raise move");
  ready_move_excl_a: assert property (!(readyOut && moveOut))
    else $error("ready and move both high");
  release_decel_a: assert property (
    r.state == spm_pkg::ST_RUN && !reqFwd && !reqRev && !r.tlcOut
    |=> r.state == spm_pkg::ST_DECEL && moveOut)
    else $error("release did not start deceleration");
  both_cmds_stop_a: assert property (
    r.state == spm_pkg::ST_RUN && conflict && !r.tlcOut
    |=> r.state == spm_pkg::ST_DECEL)
    else $error("both commands did not stop");
  reaccel_same_a: assert property (
    r.state == spm_pkg::ST_DECEL && holdCmd && !r.tlcOut
    |=> r.state == spm_pkg::ST_RUN)
    else $error("same direction did not re-accelerate");
  rest_ready_a: assert property (
    r.state == spm_pkg::ST_DECEL && !holdCmd && speedNow == 0 && !r.tlcOut
    |=> readyOut && !moveOut ##1 readyOut)
    else $error("ready not raised at rest");
  deviation_hold_a: assert property (
    // the alarm edge frees the step gate while the ramp is still being killed
    torque_limit_flag && !alarmOut && motorBlocked && $stable(motorBlocked)
    |=> r.deviation <= r.devLimit && !stepPulse)
    else $error("deviation grew past limit");
  overload_alarm_a: assert property (
    torque_limit_flag && r.ovlCnt == OVERLOAD_CYC - 1
    |=> alarmOut && !moveOut ##1 speedNow == 0)
    else $error("overload did not raise alarm");
endmodule // spm_motion_ctrl
`default_nettype wire

//--- hw/spm_pkg.sv
// shared constants, types and state records for the speed/push motion sequencer
`default_nettype none
package spm_pkg;
  localparam int unsigned CLK_HZ = 32'h0BEB_C200;
  localparam int unsigned OVERLOAD_S = 32'h0000_0005;
  localparam int unsigned OVERLOAD_CYC = OVERLOAD_S * CLK_HZ;
  localparam int N_ENT = 8;
  localparam int SEL_W = 3;
  // value ranges and values after reset
  localparam logic signed [31:0] SPEED_MAX = 32'sh003D_0900;
  localparam logic [31:0] RATE_MAX = 32'h3B9A_CA00;
  localparam logic [31:0] RATE_MIN = 32'h0000_0001;
  localparam logic [31:0] CUR_MAX = 32'h0000_03E8;
  localparam logic signed [31:0] SPEED_RST = 32'sh0000_03E8;
  localparam logic [31:0] RATE_RST = 32'h000F_4240;
  localparam logic [9:0] CUR_RST = 10'h3E8;
  localparam logic [31:0] START_RST = 32'h0000_01F4;
  localparam logic [31:0] DEVLIM_RST = 32'h0000_0100;
  // register map, byte offsets
  localparam logic [9:0] TBL_END = 10'h080;
  localparam logic [1:0] ENT_SPEED = 2'h0;
  localparam logic [1:0] ENT_RATE = 2'h1;
  localparam logic [1:0] ENT_STOP = 2'h2;
  localparam logic [1:0] ENT_CUR = 2'h3;
  localparam logic [9:0] START_OFS = 10'h100;
  localparam logic [9:0] DEVLIM_OFS = 10'h104;
  localparam logic [9:0] CTRL_OFS = 10'h108;
  localparam logic [9:0] STATUS_OFS = 10'h10C;
  localparam logic [9:0] SPEED_OFS = 10'h110;
  localparam logic [9:0] DEV_OFS = 10'h114;
  localparam int CTRL_CLR_BIT = 0;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_ALARM} spm_state_e;

  typedef struct packed {
    logic fwdSpeed;
    logic revSpeed;
    logic fwdPush;
    logic revPush;
  } spm_cmd_s;

  typedef struct packed {
    logic signed [31:0] speed;
    logic [31:0] rate;
    logic [31:0] stopDec;
    logic [9:0] current;
  } spm_entry_s;

  typedef struct packed {
    logic signed [31:0] speed;
    logic [31:0] acc;
  } spm_ramp_s;

  typedef struct packed {
    spm_state_e state;
    logic modePush;
    logic dirRev;
    logic [SEL_W-1:0] sel;
    logic readyOut;
    logic moveOut;
    logic alarmOut;
    logic tlcOut;
    logic stepOut;
    logic stepDir;
    logic [9:0] currentOut;
    logic [31:0] phase;
    logic [31:0] deviation;
    logic [31:0] ovlCnt;
    logic [31:0] startSpeed;
    logic [31:0] devLimit;
    spm_entry_s [N_ENT-1:0] tbl;
    logic [9:0] busAddr;
    logic busWr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } spm_core_s;
endpackage
`default_nettype wire

//--- hw/spm_ramp.sv
// speed ramp: starting speed jump, linear accel/decel, snap to rest
`default_nettype none
module spm_ramp (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // profile request
  input wire logic signed [31:0] target,
  input wire logic [31:0] rate,
  input wire logic [31:0] startSpeed,
  input wire logic kill,
  // present speed, Hz
  output logic signed [31:0] speedNow
);
  spm_pkg::spm_ramp_s r;
  spm_pkg::spm_ramp_s n;
  logic [31:0] tMag;
  logic [31:0] sMag;
  logic [31:0] rateC;
  logic [32:0] sum;

  always_comb begin
    n = r;
    tMag = target < 0 ? 32'(-target) : 32'(target);
    sMag = r.speed < 0 ? 32'(-r.speed) : 32'(r.speed);
    // one 1 Hz step per cycle at most: rates at or above the clock rate saturate
    rateC = rate >= spm_pkg::CLK_HZ ? spm_pkg::CLK_HZ - 32'h1 : rate;
    sum = {1'b0, r.acc} + {1'b0, rateC};
    if (kill) begin
      n.speed = '0;
      n.acc = '0;
    end else if (r.speed == 0 && target != 0) begin
      // start at the starting speed, or the target if lower
      n.speed = tMag < startSpeed ? target
              : (target < 0 ? -$signed(startSpeed) : $signed(startSpeed));
      n.acc = '0;
    end else if (target == 0 && sMag <= startSpeed) begin
      n.speed = '0;
      n.acc = '0;
    end else if (r.speed != target) begin
      if (sum >= {1'b0, spm_pkg::CLK_HZ}) begin
        n.acc = 32'(sum - {1'b0, spm_pkg::CLK_HZ});
        n.speed = r.speed < target ? r.speed + 32'sh1 : r.speed - 32'sh1;
      end else begin
        n.acc = sum[31:0];
      end
    end else begin
      n.acc = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign speedNow = r.speed;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  kill_zero_a: assert property (kill |=> speedNow == 0)
    else $error("speed not zero after kill");
  start_jump_a: assert property (
    (!kill && speedNow == 0 && target > 0 && target >= $signed(startSpeed))
    |=> speedNow == $signed($past(startSpeed)))
    else $error("start did not jump to starting speed");
endmodule // spm_ramp
`default_nettype wire

//--- verification/spm_host_model.sv
// host-side model driving the direct command inputs of the sequencer
`default_nettype none
module spm_host_model (
  // clock
  input wire logic clk_sys,
  // bench request and sequencer status
  input wire spm_pkg::spm_cmd_s req,
  input wire logic readyOut,
  input wire logic moveOut,
  // command pins
  output var spm_pkg::spm_cmd_s cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cmd = '0;
  // a new start waits for ready; once moving the host may drop or re-raise freely
  always @(posedge clk_sys) begin
    if (readyOut === 1'b1 || moveOut === 1'b1) begin
      cmd <= req;
    end else begin
      cmd <= '0;
    end
  end
endmodule // spm_host_model
`default_nettype wire

//--- verification/spm_motion_ctrl_tb_top.sv
// self-checking bench for the speed and push-motion sequencer
`default_nettype none
module spm_motion_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // short overload count keeps the alarm scenario brief
  localparam int unsigned OVL = 50;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0] sel = 3'h0;
  logic motorBlocked = 1'b0;
  spm_pkg::spm_cmd_s hostReq = '0;
  spm_pkg::spm_cmd_s hostCmd;
  logic hreadyout, hresp, readyOut, moveOut, alarmOut, tlcFlag, stepPulse, stepDirRev;
  logic [31:0] hrdata;
  logic [9:0] currentSet;
  logic [31:0] rd;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  initial forever #2.5 clk_sys = ~clk_sys;

  spm_motion_ctrl #(.OVERLOAD_CYC(OVL)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fwd_speed_cmd(hostCmd.fwdSpeed), .rev_speed_cmd(hostCmd.revSpeed),
    .fwd_push_cmd(hostCmd.fwdPush), .rev_push_cmd(hostCmd.revPush),
    .data_select_bit0(sel[0]), .data_select_bit1(sel[1]), .data_select_bit2(sel[2]),
    .motorBlocked(motorBlocked), .readyOut(readyOut), .moveOut(moveOut),
    .alarmOut(alarmOut), .torque_limit_flag(tlcFlag), .stepPulse(stepPulse),
    .stepDirRev(stepDirRev), .currentSet(currentSet)
  );

  spm_host_model u_host (
    .clk_sys(clk_sys), .req(hostReq), .readyOut(readyOut), .moveOut(moveOut),
    .cmd(hostCmd)
  );

  ////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("MISMATCH %0t timeout", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one single transfer; hresp is always OKAY, so only hready paces it
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask

  task automatic wait_ready(input logic v, input int lim);
    n = 0;
    while (readyOut !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(readyOut), 32'(v), "ready level");
  endtask

  ////////////////////////////////////////
  task automatic t_reset();
    chk(32'(readyOut), 32'h1, "ready after reset");
    chk(32'(currentSet), 32'h3E8, "current after reset");
    rdchk(32'h0000_0000, 32'h0000_03E8, "entry speed");
    rdchk(32'h0000_0004, 32'h000F_4240, "entry rate");
    rdchk(32'h0000_0008, 32'h000F_4240, "entry stop");
    ahb(1'b1, 32'(spm_pkg::START_OFS), 32'h003D_0901);
    rdchk(32'(spm_pkg::START_OFS), 32'h0000_01F4, "start speed");
    rdchk(32'h0000_0200, 32'h0000_0000, "unmapped");
    // full rate of 1 Hz per cycle keeps ramps a few hundred cycles long
    for (int e = 0; e < 2; e++) begin
      ahb(1'b1, 32'(e * 16 + 4), 32'h0BEB_C200);
      ahb(1'b1, 32'(e * 16 + 8), 32'h0BEB_C200);
    end
    ahb(1'b1, 32'h0000_0010, 32'h0000_05DC);
  endtask

  task automatic t_fwd();
    hostReq.fwdSpeed <= 1'b1;
    wait_ready(1'b0, 20);
    chk(32'(moveOut), 32'h1, "move on start");
    repeat (700) @(posedge clk_sys);
    rdchk(32'(spm_pkg::SPEED_OFS), 32'h0000_03E8, "fwd speed");
    chk(32'(stepDirRev), 32'h0, "fwd dir");
    hostReq.fwdSpeed <= 1'b0;
    repeat (20) @(posedge clk_sys);
    ahb(1'b0, 32'(spm_pkg::SPEED_OFS), 32'h0000_0000);
    chk(32'($signed(rd) < 32'sd1000 && moveOut === 1'b1), 32'h1, "decel");
    wait_ready(1'b1, 2000);
    chk(32'(moveOut), 32'h0, "move at rest");
  endtask

  task automatic t_rev();
    hostReq.revSpeed <= 1'b1;
    wait_ready(1'b0, 20);
    repeat (700) @(posedge clk_sys);
    rdchk(32'(spm_pkg::SPEED_OFS), 32'hFFFF_FC18, "rev speed");
    chk(32'(stepDirRev), 32'h1, "rev dir");
    sel <= 3'h1;
    repeat (700) @(posedge clk_sys);
    rdchk(32'(spm_pkg::SPEED_OFS), 32'hFFFF_FA24, "entry change");
    chk(32'(readyOut), 32'h0, "no stop on change");
    hostReq.revSpeed <= 1'b0;
    repeat (20) @(posedge clk_sys);
    hostReq.revSpeed <= 1'b1;
    repeat (300) @(posedge clk_sys);
    rdchk(32'(spm_pkg::SPEED_OFS), 32'hFFFF_FA24, "reaccel");
    chk(32'(moveOut), 32'h1, "reaccel move");
    hostReq.revSpeed <= 1'b0;
    sel <= 3'h0;
    wait_ready(1'b1, 3000);
  endtask

  task automatic t_both();
    hostReq <= 4'hC;
    repeat (10) @(posedge clk_sys);
    chk(32'({readyOut, moveOut}), 32'h2, "both speed");
    hostReq <= 4'h3;
    repeat (10) @(posedge clk_sys);
    chk(32'({readyOut, moveOut}), 32'h2, "both push");
    hostReq <= 4'h0;
  endtask

  task automatic t_push();
    int t0;
    // start speed at the target skips the ramp, so steps come every 50 cycles
    ahb(1'b1, 32'(spm_pkg::START_OFS), 32'h003D_0900);
    ahb(1'b1, 32'h0000_0020, 32'h003D_0900);
    ahb(1'b1, 32'h0000_002C, 32'h0000_012C);
    ahb(1'b1, 32'h0000_002C, 32'h0000_03E9);
    rdchk(32'h0000_002C, 32'h0000_012C, "current range");
    ahb(1'b1, 32'(spm_pkg::DEVLIM_OFS), 32'h0000_0004);
    sel <= 3'h2;
    hostReq.fwdPush <= 1'b1;
    wait_ready(1'b0, 20);
    repeat (20) @(posedge clk_sys);
    chk(32'(currentSet), 32'h0000_012C, "push current");
    rdchk(32'(spm_pkg::SPEED_OFS), 32'h003D_0900, "push speed");
    hostReq.fwdPush <= 1'b0;
    wait_ready(1'b1, 100);
    motorBlocked <= 1'b1;
    hostReq.fwdPush <= 1'b1;
    n = 0;
    while (tlcFlag !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(tlcFlag), 32'h1, "torque limit");
    t0 = cycles;
    // the deviation is cleared once the alarm stops the motor, so read it before
    rdchk(32'(spm_pkg::DEV_OFS), 32'h0000_0004, "deviation held");
    n = 0;
    while (alarmOut !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(cycles - t0 >= OVL - 2 && cycles - t0 <= OVL + 2), 32'h1, "overload time");
    chk(32'(moveOut), 32'h0, "alarm stop");
    hostReq.fwdPush <= 1'b0;
    motorBlocked <= 1'b0;
    ahb(1'b1, 32'(spm_pkg::CTRL_OFS), 32'h0000_0001);
    wait_ready(1'b1, 20);
    chk(32'(alarmOut), 32'h0, "alarm cleared");
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_fwd();
    t_rev();
    t_both();
    t_push();
    end_sim();
  end
endmodule // spm_motion_ctrl_tb_top
`default_nettype wire
